//--- sdfa_pkg.sv
`default_nettype none
package sdfa_pkg;

    localparam int unsigned FRONT_PORTS = 11;
    localparam int unsigned MASK_W      = 12;
    localparam int unsigned CPU_BIT     = 11;
    localparam int unsigned QUEUE_W     = 3;
    localparam int unsigned QUEUES      = 8;
    localparam int unsigned TABLE_DEPTH = 64;
    localparam int unsigned INDEX_W     = 6;
    localparam int unsigned ETYPE_W     = 2;

    localparam logic [47:0] DMAC_BROADCAST   = 48'hffffffffffff;
    localparam int unsigned DMAC_GROUP_BIT   = 40;
    localparam logic [23:0] MC4_DMAC_OUI     = 24'h01005e;
    localparam int unsigned MC4_DMAC_TOP_BIT = 23;
    localparam logic [15:0] MC6_DMAC_PREFIX  = 16'h3333;
    localparam logic [15:0] ETHERTYPE_IPV4   = 16'h0800;
    localparam logic [15:0] ETHERTYPE_IPV6   = 16'h86dd;
    localparam logic [7:0]  IP_PROTO_IGMP    = 8'h02;
    localparam logic [23:0] IPV4_LOCAL_NET   = 24'he00000;
    localparam logic [15:0] IPV6_LOCAL_NET   = 16'hff02;

    localparam logic [ETYPE_W-1:0] ENTRY_TYPE_A = 2'h0;
    localparam logic [ETYPE_W-1:0] ENTRY_TYPE_B = 2'h1;

    typedef enum logic [2:0] {
        FLOOD_UNICAST   = 3'h0,
        FLOOD_BROADCAST = 3'h1,
        FLOOD_MULTICAST = 3'h2,
        FLOOD_MC4_CTRL  = 3'h3,
        FLOOD_MC4_DATA  = 3'h4,
        FLOOD_MC6_CTRL  = 3'h5,
        FLOOD_MC6_DATA  = 3'h6
    } sdfa_flood_type;

    typedef struct packed {
        logic [MASK_W-1:0]  mask;
        logic [QUEUE_W-1:0] queue;
    } sdfa_group_type;

    typedef struct packed {
        sdfa_group_type [TABLE_DEPTH-1:0] groupTable;
        logic                             outValid;
        logic [FRONT_PORTS-1:0]           portSetA;
        logic [QUEUES-1:0]                cpuQueueMask;
        logic                             learnEnable;
        logic                             learnInsert;
        logic                             learnUpdate;
    } sdfa_state_type;

    function automatic logic [QUEUES-1:0] queue_bit(
        input logic [QUEUE_W-1:0] q
    );
        queue_bit = '0;
        queue_bit[q] = 1'b1;
    endfunction : queue_bit

endpackage : sdfa_pkg
`default_nettype wire

//--- sdfa_class_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sdfa_class_if;
    logic [47:0]             dmac;
    logic [15:0]             etherType;
    logic [7:0]              ipProto;
    logic [31:0]             dip4;
    logic [15:0]             dip6Top;
    sdfa_pkg::sdfa_flood_type floodType;

    modport classifier (
        input  dmac,
        input  etherType,
        input  ipProto,
        input  dip4,
        input  dip6Top,
        output floodType
    );
    modport user (
        output dmac,
        output etherType,
        output ipProto,
        output dip4,
        output dip6Top,
        input  floodType
    );
endinterface : sdfa_class_if
`default_nettype wire

//--- sdfa_flood_class.sv
`timescale 1ns/100ps
`default_nettype none
module sdfa_flood_class (
    sdfa_class_if.classifier cls    // Frame fields in, flood type out
);
    logic mc4Mac;
    logic mc6Mac;
    logic mc4Frame;
    logic mc6Frame;

    always_comb begin
        mc4Mac = (cls.dmac[47:24] == sdfa_pkg::MC4_DMAC_OUI)
                 && !cls.dmac[sdfa_pkg::MC4_DMAC_TOP_BIT];
        mc6Mac = (cls.dmac[47:32] == sdfa_pkg::MC6_DMAC_PREFIX);
        mc4Frame = mc4Mac
                   && (cls.etherType == sdfa_pkg::ETHERTYPE_IPV4)
                   && (cls.ipProto != sdfa_pkg::IP_PROTO_IGMP);
        mc6Frame = mc6Mac && (cls.etherType == sdfa_pkg::ETHERTYPE_IPV6);
        // IP classes first so the plain multicast mask only catches the rest
        if (mc4Frame) begin
            if (cls.dip4[31:8] == sdfa_pkg::IPV4_LOCAL_NET) begin
                cls.floodType = sdfa_pkg::FLOOD_MC4_CTRL; // R10
            end else begin
                cls.floodType = sdfa_pkg::FLOOD_MC4_DATA; // R9
            end
        end else if (mc6Frame) begin
            if (cls.dip6Top == sdfa_pkg::IPV6_LOCAL_NET) begin
                cls.floodType = sdfa_pkg::FLOOD_MC6_CTRL; // R12
            end else begin
                cls.floodType = sdfa_pkg::FLOOD_MC6_DATA; // R11
            end
        end else if (cls.dmac == sdfa_pkg::DMAC_BROADCAST) begin
            cls.floodType = sdfa_pkg::FLOOD_BROADCAST; // R14
        end else if (cls.dmac[sdfa_pkg::DMAC_GROUP_BIT]) begin
            cls.floodType = sdfa_pkg::FLOOD_MULTICAST; // R13
        end else begin
            cls.floodType = sdfa_pkg::FLOOD_UNICAST; // R13
        end
    end

endmodule : sdfa_flood_class
`default_nettype wire

//--- sdfa_forward.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// R1: Each request runs all forwarding steps, building port set and queues.
// R2: Port set holds front ports only; CPU reached only through queue mask.
// R3: Learning disabled flag suppresses learning; otherwise normal learning.
// R4: Learn frames insert a new entry or update an existing one.
// R5: Exact destination MAC and VLAN hit gives port set from the entry.
// R6: Hit of entry type 0 or 1 with CPU in mask adds mask's queue.
// R7: On a miss, flood with one of seven flood masks by flood type.
// R8: Each flood type has its own index into the 64-entry mask table.
// R9: IPv4 multicast MAC, IPv4, not IGMP, address outside 224.0.0.x is data.
// R10: Same IPv4 conditions with address inside 224.0.0.x is control.
// R11: IPv6 multicast MAC, IPv6, address outside ff02::/16 is data.
// R12: Same IPv6 conditions with address inside ff02::/16 is control.
// R13: Group bit set otherwise is multicast; group bit clear is unicast.
// R14: All-ones destination MAC is broadcast and uses broadcast index.
// R15: Entry CPU copy flag adds the configured MAC-copy queue.
// R16: Ignore-entry-flags control disables the entry CPU copy flag.
// R17: Classifier CPU copy adds the classifier's queue.
// R18: Classifier redirect clears port set and adds the classifier's queue.
// R19: Source lookup copy request adds its carried queue number.
// R20: Source lookup discard request clears the port set.
module sdfa_forward (
    input  wire logic        ref_clk,               // Core clock
    input  wire logic        sys_rst,               // Sync reset, high
    // Analyzer request
    input  wire logic        reqValid,              // Request strobe
    input  wire logic [47:0] reqDmac,               // Destination MAC
    input  wire logic [15:0] reqEtherType,          // EtherType
    input  wire logic [7:0]  reqIpProto,            // IPv4 protocol
    input  wire logic [31:0] reqDip4,               // IPv4 destination
    input  wire logic [15:0] reqDip6Top,            // IPv6 destination top bits
    input  wire logic        reqLearnFrame,         // Frame is learn frame
    input  wire logic        learnDisableFlag,      // Per-frame learn off
    input  wire logic        srcEntryHit,           // Source entry exists
    // Destination lookup result
    input  wire logic        lookupHit,             // MAC and VLAN matched
    input  wire logic [5:0]  entryMaskIndex,        // Entry's mask index
    input  wire logic [1:0]  entryType,             // Entry type
    input  wire logic        entryCpuCopyFlag,      // Entry copy flag
    // Classifier and source lookup results
    input  wire logic        clsCpuCopy,            // Classifier copy
    input  wire logic        clsCpuRedirect,        // Classifier redirect
    input  wire logic [2:0]  clsCpuQueue,           // Classifier queue
    input  wire logic        cpuCopyRequest,        // Source action copy
    input  wire logic [2:0]  cpuQueueNumber,        // Source action queue
    input  wire logic        discardRequest,        // Source action kill
    // Configuration
    input  wire logic [5:0]  unicastFloodIndex,     // Unicast mask index
    input  wire logic [5:0]  broadcastFloodIndex,   // Broadcast index
    input  wire logic [5:0]  multicastFloodIndex,   // Multicast index
    input  wire logic [5:0]  ipv4McControlFloodIndex, // IPv4 ctrl index
    input  wire logic [5:0]  ipv4McDataFloodIndex,  // IPv4 data index
    input  wire logic [5:0]  ipv6McControlFloodIndex, // IPv6 ctrl index
    input  wire logic [5:0]  ipv6McDataFloodIndex,  // IPv6 data index
    input  wire logic        ignoreDestEntryFlags,  // Ignore entry flags
    input  wire logic [2:0]  macCopyCpuQueue,       // Queue for MAC copy
    // Mask table write port
    input  wire logic        tableWrEn,             // Write strobe
    input  wire logic [5:0]  tableWrIndex,          // Entry to write
    input  wire logic [11:0] tableWrMask,           // Ports, bit 11 CPU
    input  wire logic [2:0]  tableWrQueue,          // Mask queue field
    // Forwarding result
    output logic             resValid,              // Result strobe
    output logic [10:0]      portSetA,              // Front port set
    output logic [7:0]       cpuQueueMask,          // CPU queue mask
    output logic             learnEnable,           // Learning allowed
    output logic             learnInsert,           // Insert new entry
    output logic             learnUpdate            // Update entry
);
    sdfa_pkg::sdfa_state_type st_r;
    sdfa_pkg::sdfa_state_type st_nxt;
    sdfa_class_if             clsIf ();

    logic [sdfa_pkg::INDEX_W-1:0]     floodIndex;
    sdfa_pkg::sdfa_group_type         group;
    logic [sdfa_pkg::FRONT_PORTS-1:0] port_set_a;
    logic [sdfa_pkg::QUEUES-1:0]      queues;
    logic                             learnOk;

    assign clsIf.dmac      = reqDmac;
    assign clsIf.etherType = reqEtherType;
    assign clsIf.ipProto   = reqIpProto;
    assign clsIf.dip4      = reqDip4;
    assign clsIf.dip6Top   = reqDip6Top;

    sdfa_flood_class uClass (
        .cls (clsIf.classifier)
    );

    always_comb begin
        st_nxt = st_r;
        // Flood index per type
        case (clsIf.floodType)
            sdfa_pkg::FLOOD_UNICAST:   floodIndex = unicastFloodIndex; // R8
            sdfa_pkg::FLOOD_BROADCAST: floodIndex = broadcastFloodIndex; // R8
            sdfa_pkg::FLOOD_MULTICAST: floodIndex = multicastFloodIndex; // R8
            sdfa_pkg::FLOOD_MC4_CTRL: begin
                floodIndex = ipv4McControlFloodIndex; // R8
            end
            sdfa_pkg::FLOOD_MC4_DATA:  floodIndex = ipv4McDataFloodIndex; // R8
            sdfa_pkg::FLOOD_MC6_CTRL: begin
                floodIndex = ipv6McControlFloodIndex; // R8
            end
            sdfa_pkg::FLOOD_MC6_DATA:  floodIndex = ipv6McDataFloodIndex; // R8
            default:                   floodIndex = unicastFloodIndex;
        endcase
        // Step 1: destination lookup or flooding
        if (lookupHit) begin
            group = st_r.groupTable[entryMaskIndex]; // R5
        end else begin
            group = st_r.groupTable[floodIndex]; // R7
        end
        // CPU bit never leaks into the port set
        port_set_a   = group.mask[sdfa_pkg::FRONT_PORTS-1:0]; // R2
        queues = '0;
        if (lookupHit && group.mask[sdfa_pkg::CPU_BIT]
            && (entryType == sdfa_pkg::ENTRY_TYPE_A
                || entryType == sdfa_pkg::ENTRY_TYPE_B)) begin
            queues = queues | sdfa_pkg::queue_bit(group.queue); // R6
        end
        // Step 2: entry copy flag
        if (lookupHit && entryCpuCopyFlag
            && !ignoreDestEntryFlags) begin // R16
            queues = queues | sdfa_pkg::queue_bit(macCopyCpuQueue); // R15
        end
        // Step 3: classifier copy and redirect
        if (clsCpuCopy || clsCpuRedirect) begin
            queues = queues | sdfa_pkg::queue_bit(clsCpuQueue); // R17
        end
        if (clsCpuRedirect) begin
            port_set_a = '0; // R18
        end
        // Step 4: source lookup action
        if (cpuCopyRequest) begin
            queues = queues | sdfa_pkg::queue_bit(cpuQueueNumber); // R19
        end
        if (discardRequest) begin
            port_set_a = '0; // R20
        end
        learnOk = reqLearnFrame && !learnDisableFlag; // R3
        // Outputs hold the last result; strobes last one cycle
        st_nxt.outValid    = reqValid; // R1
        st_nxt.learnEnable = reqValid && learnOk; // R3
        st_nxt.learnInsert = reqValid && learnOk && !srcEntryHit; // R4
        st_nxt.learnUpdate = reqValid && learnOk && srcEntryHit; // R4
        if (reqValid) begin
            st_nxt.portSetA     = port_set_a; // R1
            st_nxt.cpuQueueMask = queues; // R1
        end
        // A write lands after the lookup of the same cycle
        if (tableWrEn) begin
            st_nxt.groupTable[tableWrIndex].mask  = tableWrMask;
            st_nxt.groupTable[tableWrIndex].queue = tableWrQueue;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign resValid     = st_r.outValid;
    assign portSetA     = st_r.portSetA;
    assign cpuQueueMask = st_r.cpuQueueMask;
    assign learnEnable  = st_r.learnEnable;
    assign learnInsert  = st_r.learnInsert;
    assign learnUpdate  = st_r.learnUpdate;

endmodule : sdfa_forward
`default_nettype wire

//--- sdfa_forward_props.sv
`timescale 1ns/100ps
`default_nettype none
module sdfa_forward_chk (
    input wire logic        ref_clk,          // Clock
    input wire logic        sys_rst,          // Reset
    input wire logic        reqValid,         // Request
    input wire logic        reqLearnFrame,    // Learn frame
    input wire logic        learnDisableFlag, // Learn off
    input wire logic        srcEntryHit,      // Source known
    input wire logic        clsCpuRedirect,   // Redirect
    input wire logic        discardRequest,   // Discard
    input wire logic        cpuCopyRequest,   // Source copy
    input wire logic [2:0]  cpuQueueNumber,   // Source queue
    input wire logic        resValid,         // Result
    input wire logic [10:0] portSetA,         // Port set
    input wire logic [7:0]  cpuQueueMask,     // Queue mask
    input wire logic        learnEnable,      // Learn
    input wire logic        learnInsert,      // Insert
    input wire logic        learnUpdate       // Update
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    logic lrn;
    assign lrn = reqLearnFrame && !learnDisableFlag;
    property p_ans; reqValid |=> resValid; endproperty
    a_ans: assert property (p_ans) else $error("no result");
    property p_idle; !reqValid |=> !resValid && $stable(portSetA); endproperty
    a_idle: assert property (p_idle) else $error("stray result");
    property p_lrn; reqValid |=> learnEnable == $past(lrn); endproperty
    a_lrn: assert property (p_lrn) else $error("learn enable");
    property p_ins; reqValid |=> learnInsert == $past(lrn && !srcEntryHit);
    endproperty
    a_ins: assert property (p_ins) else $error("learn insert");
    property p_upd; reqValid |=> learnUpdate == $past(lrn && srcEntryHit);
    endproperty
    a_upd: assert property (p_upd) else $error("learn update");
    property p_red; reqValid && clsCpuRedirect |=> portSetA == '0; endproperty
    a_red: assert property (p_red) else $error("redirect kept ports");
    property p_kill; reqValid && discardRequest |=> portSetA == '0; endproperty
    a_kill: assert property (p_kill) else $error("discard kept ports");
    property p_scp;
        reqValid && cpuCopyRequest |=> cpuQueueMask[$past(cpuQueueNumber)];
    endproperty
    a_scp: assert property (p_scp) else $error("source copy queue");
    // Learn strobes must never outlive the result strobe
    property p_pulse;
        !resValid |-> !(learnEnable || learnInsert || learnUpdate);
    endproperty
    a_pulse: assert property (p_pulse) else $error("learn strobe");
    c_red: cover property (reqValid && clsCpuRedirect);
    c_kill: cover property (reqValid && discardRequest);
    c_upd: cover property (resValid && learnUpdate);
endmodule : sdfa_forward_chk
bind sdfa_forward sdfa_forward_chk u_chk (.*);
`default_nettype wire

//--- sdfa_mac_model.sv
`timescale 1ns/100ps
`default_nettype none
module sdfa_mac_model (
    input  wire logic [47:0] dmac,    // Looked-up MAC
    input  wire logic [47:0] keyDmac, // Stored entry MAC
    input  wire logic [5:0]  keyIdx,  // Stored mask index
    input  wire logic [1:0]  keyType, // Stored entry type
    input  wire logic        keyCopy, // Stored copy flag
    output logic             hit,     // Exact match
    output logic [5:0]       idx,     // Mask index
    output logic [1:0]       eType,   // Entry type
    output logic             copy     // Copy flag
);
    // On a miss the entry fields turn to junk, so none may be trusted
    assign hit   = dmac === keyDmac;
    assign idx   = hit ? keyIdx : ~keyIdx;
    assign eType = hit ? keyType : ~keyType;
    assign copy  = hit ? keyCopy : ~keyCopy;
endmodule : sdfa_mac_model
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        ref_clk, sys_rst, reqValid, reqLearnFrame, learnDisableFlag;
    logic        srcEntryHit, lookupHit, entryCpuCopyFlag, clsCpuCopy;
    logic        clsCpuRedirect, cpuCopyRequest, discardRequest, keyCopy;
    logic        ignoreDestEntryFlags, tableWrEn, resValid, learnEnable;
    logic        learnInsert, learnUpdate;
    logic [47:0] reqDmac, keyDmac;
    logic [31:0] reqDip4;
    logic [15:0] reqEtherType, reqDip6Top;
    logic [11:0] tableWrMask;
    logic [10:0] portSetA;
    logic [7:0]  reqIpProto, cpuQueueMask;
    logic [5:0]  entryMaskIndex, keyIdx, tableWrIndex, fi[7];
    logic [2:0]  clsCpuQueue, cpuQueueNumber, macCopyCpuQueue, tableWrQueue;
    logic [1:0]  entryType, keyType;
    int          num_errors = 0;
    int          compares = 0;

    sdfa_mac_model u_mac (.dmac(reqDmac), .keyDmac(keyDmac), .keyIdx(keyIdx),
        .keyType(keyType), .keyCopy(keyCopy), .hit(lookupHit),
        .idx(entryMaskIndex), .eType(entryType), .copy(entryCpuCopyFlag));
    sdfa_forward dut (.*, .unicastFloodIndex(fi[0]),
        .broadcastFloodIndex(fi[1]), .multicastFloodIndex(fi[2]),
        .ipv4McControlFloodIndex(fi[3]), .ipv4McDataFloodIndex(fi[4]),
        .ipv6McControlFloodIndex(fi[5]), .ipv6McDataFloodIndex(fi[6]));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic report_and_stop;
        if (num_errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [5:0] i, input logic [11:0] m,
                      input logic [2:0] q);
        @(posedge ref_clk);
        #1 {tableWrEn, tableWrIndex} = {1'b1, i};
        {tableWrMask, tableWrQueue} = {m, q};
        @(posedge ref_clk);
        #1 tableWrEn = 1'b0;
    endtask : wr

    // Leaves the caller in the cycle where the one-cycle strobes stand
    task automatic go;
        @(posedge ref_clk);
        #1 reqValid = 1'b1;
        @(posedge ref_clk);
        #1 reqValid = 1'b0;
        chk(resValid, 1'b1);
    endtask : go

    task automatic t_flood;
        logic [47:0] dm[8] = '{48'h000102030405, 48'hffffffffffff,
            48'h010000000001, 48'h01005e000001, 48'h01005e7fffff,
            48'h333300000001, 48'h3333ffffffff, 48'h01005e000002};
        int ty[8] = '{0, 1, 2, 3, 4, 5, 6, 2};
        for (int i = 0; i < 7; i++) begin
            fi[i] = 6'(i + 1);
            wr(6'(i + 1), {1'b1, 11'h001 << i}, 3'h3);
        end
        for (int i = 0; i < 8; i++) begin
            reqDmac = dm[i];
            reqEtherType = dm[i][47:32] == 16'h3333 ? 16'h86dd : 16'h0800;
            reqIpProto = i == 7 ? 8'h02 : 8'h11;
            reqDip4 = i == 4 ? 32'he0000101 : 32'he0000001;
            reqDip6Top = i == 6 ? 16'hff05 : 16'hff02;
            go;
            chk(portSetA, 11'h001 << ty[i]);
            chk(cpuQueueMask, 8'h00);
        end
    endtask : t_flood

    task automatic t_hit;
        {keyIdx, keyType} = {6'h14, 2'h0};
        {keyCopy, macCopyCpuQueue} = {1'b1, 3'h2};
        wr(6'h14, 12'h805, 3'h5);
        reqDmac = keyDmac;
        go;
        chk(portSetA, 11'h005);
        chk(cpuQueueMask, 8'h24);
        ignoreDestEntryFlags = 1'b1;
        go;
        chk(cpuQueueMask, 8'h20);
        {ignoreDestEntryFlags, keyType} = {1'b0, 2'h1};
        go;
        chk(cpuQueueMask, 8'h24);
        keyType = 2'h2;
        go;
        chk(cpuQueueMask, 8'h04);
    endtask : t_hit

    task automatic t_act;
        {clsCpuCopy, clsCpuQueue} = {1'b1, 3'h1};
        go;
        chk(cpuQueueMask, 8'h06);
        chk(portSetA, 11'h005);
        {clsCpuCopy, clsCpuRedirect, clsCpuQueue} = {2'b01, 3'h6};
        go;
        chk(portSetA, 11'h000);
        chk(cpuQueueMask, 8'h44);
        clsCpuRedirect = 1'b0;
        {cpuCopyRequest, cpuQueueNumber, discardRequest} = {1'b1, 3'h7, 1'b1};
        go;
        chk(portSetA, 11'h000);
        chk(cpuQueueMask, 8'h84);
        {cpuCopyRequest, discardRequest} = 2'b00;
    endtask : t_act

    task automatic t_learn;
        for (int i = 0; i < 8; i++) begin
            {reqLearnFrame, learnDisableFlag, srcEntryHit} = i[2:0];
            go;
            chk(learnEnable, i == 4 || i == 5);
            chk(learnInsert, i == 4);
            chk(learnUpdate, i == 5);
        end
    endtask : t_learn

    task automatic t_b2b;
        reqDmac = 48'hffffffffffff;
        @(posedge ref_clk);
        #1 reqValid = 1'b1;
        @(posedge ref_clk);
        #1 reqDmac = keyDmac;
        chk(portSetA, 11'h002);
        @(posedge ref_clk);
        #1 reqValid = 1'b0;
        chk(resValid, 1'b1);
        chk(portSetA, 11'h005);
        @(posedge ref_clk);
        #1 chk(resValid, 1'b0);
        chk(portSetA, 11'h005);
    endtask : t_b2b

    initial begin
        {reqValid, reqLearnFrame, learnDisableFlag, srcEntryHit, clsCpuCopy,
         clsCpuRedirect, cpuCopyRequest, discardRequest, keyCopy,
         ignoreDestEntryFlags, tableWrEn} = '0;
        {reqDmac, keyDmac, reqDip4, reqEtherType, reqDip6Top, reqIpProto,
         tableWrMask, tableWrIndex, clsCpuQueue, cpuQueueNumber,
         macCopyCpuQueue, tableWrQueue, keyIdx, keyType} = '0;
        fi = '{default: 6'h00};
        sys_rst = 1'b1;
        repeat (6) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
        keyDmac = 48'h00aa00000001;
        chk({resValid, portSetA, cpuQueueMask}, '0);
        t_flood();
        t_hit();
        t_act();
        t_learn();
        t_b2b();
        report_and_stop();
    end

    // Whole run is under 80 cycles; this leaves ample margin
    initial begin
        #20000;
        num_errors++;
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
